// ---- design/tcsf_top.sv ----
// Purpose: control, flags and counting of the 16/8-bit reload timer
// Assumes: apb slave with zero wait states, ext_osc synchronous
// Notes: event status clears on read, flags clear by software write
//
// Chosen here: the address map and register access over APB.
`default_nettype none
// Summary of operation
// - high byte rollover sets high overflow flag
// - 16-bit wrap sets high overflow flag
// - enabled timer interrupt follows high overflow
// - high flag stays until software clears
// - low byte rollover sets low flag always
// - low interrupt needs low enable and timer enable
// - capture enable bit turns capture on
// - split select picks 16-bit or two bytes
// - 16-bit count and split high byte only while run control is one
// - split mode low byte ignores run control
// - unused control bit reads zero, ignores writes
// - clock is system/12 or external/8
// - external select applies to both bytes
// - 16-bit wrap loads both reload bytes
// - split bytes reload from own reload byte
// - per-byte select picks undivided system clock
// - capture copies count and sets high flag
module tcsf_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external oscillator, synchronous level
	input wire logic ext_osc,
	// timer interrupt request
	output logic timer_irq
);
	// apb decode
	logic setup;
	logic access;
	logic wr_acc;
	logic rd_acc;
	logic sel_ctrl;
	logic sel_clksel;
	logic sel_ie;
	logic sel_st;
	logic sel_mask;
	logic [1:0] sel_rld;
	logic [1:0] sel_cnt;
	logic hit;
	logic wr_ctrl;
	logic rd_st;
	logic [1:0] wr_rld;
	logic [1:0] wr_cnt;
	logic [31:0] rd_mux;
	logic [31:0] prdata_reg;

	// control fields of timer_control
	logic high_overflow_flag_reg;
	logic high_overflow_flag_next;
	logic low_overflow_flag_reg;
	logic low_overflow_flag_next;
	logic low_overflow_irq_enable_reg;
	logic capture_mode_enable_reg;
	logic split_mode_select_reg;
	logic run_control_reg;
	logic external_clock_select_reg;
	logic [7:0] timer_control;

	// other registers
	logic [1:0] clksel_reg;
	logic ie_reg;
	logic [1:0] evt_st_reg;
	logic [1:0] evt_st_next;
	logic [1:0] evt_mask_reg;
	logic [1:0][7:0] rld_reg;
	logic [1:0][7:0] rld_next;

	// counting
	logic sys12_tick;
	logic ext8_tick;
	logic [1:0] tick;
	logic [1:0] cnt_en;
	logic [1:0] rld_en;
	logic [1:0] wrap;
	logic [1:0][7:0] cnt;
	logic cap_evt;
	logic hov_set;
	logic lov_set;

	// zero wait state slave; unmapped words answer with an error
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_acc = access & pwrite;
	assign rd_acc = access & ~pwrite;
	assign sel_ctrl = paddr == tcsf_pkg::ADDR_CTRL;
	assign sel_rld[0] = paddr == tcsf_pkg::ADDR_RLD_LO;
	assign sel_rld[1] = paddr == tcsf_pkg::ADDR_RLD_HI;
	assign sel_cnt[0] = paddr == tcsf_pkg::ADDR_CNT_LO;
	assign sel_cnt[1] = paddr == tcsf_pkg::ADDR_CNT_HI;
	assign sel_clksel = paddr == tcsf_pkg::ADDR_CLKSEL;
	assign sel_ie = paddr == tcsf_pkg::ADDR_IE;
	assign sel_st = paddr == tcsf_pkg::ADDR_EVT_ST;
	assign sel_mask = paddr == tcsf_pkg::ADDR_EVT_MASK;
	assign hit = sel_ctrl | (|sel_rld) | (|sel_cnt) | sel_clksel |
		sel_ie | sel_st | sel_mask;
	assign pready = 1'b1;
	assign pslverr = access & ~hit;
	assign wr_ctrl = wr_acc & sel_ctrl;
	assign wr_rld = {2{wr_acc}} & sel_rld;
	assign wr_cnt = {2{wr_acc}} & sel_cnt;
	assign rd_st = rd_acc & sel_st;

	// control word as software sees it; bit 1 is wired low
	assign timer_control = {high_overflow_flag_reg,
		low_overflow_flag_reg, low_overflow_irq_enable_reg,
		capture_mode_enable_reg, split_mode_select_reg,
		run_control_reg, 1'b0, external_clock_select_reg};

	// read mux, sampled in the setup phase
	assign rd_mux = sel_ctrl ? {24'h000000, timer_control} :
		sel_rld[0] ? {24'h000000, rld_reg[0]} :
		sel_rld[1] ? {24'h000000, rld_reg[1]} :
		sel_cnt[0] ? {24'h000000, cnt[0]} :
		sel_cnt[1] ? {24'h000000, cnt[1]} :
		sel_clksel ? {30'h0000000, clksel_reg} :
		sel_ie ? {31'h0000000, ie_reg} :
		sel_st ? {30'h0000000, evt_st_reg} :
		sel_mask ? {30'h0000000, evt_mask_reg} : 32'h00000000;
	assign prdata = prdata_reg;

	// clock enables from the dividers
	tcsf_prescale u_prescale (
		.clk_sys(clk_sys),
		.rst(rst),
		.ext_osc(ext_osc),
		.sys12_tick(sys12_tick),
		.ext8_tick(ext8_tick)
	);

	// per-byte clock source: undivided, system/12 or external/8
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_byte
			assign tick[gi] = clksel_reg[gi] ? 1'b1 :
				(external_clock_select_reg ? ext8_tick :
				sys12_tick);
			tcsf_byte_cnt u_cnt (
				.clk_sys(clk_sys),
				.rst(rst),
				.count_en(cnt_en[gi]),
				.reload_en(rld_en[gi]),
				.reload_val(rld_reg[gi]),
				.wr_en(wr_cnt[gi]),
				.wr_data(pwdata[7:0]),
				.count(cnt[gi]),
				.wrap(wrap[gi])
			);
		end
	endgenerate

	// 16-bit: whole counter runs on the low byte clock under run control;
	// split: low byte free running, high byte gated by run control
	assign cnt_en[0] = split_mode_select_reg ? tick[0] :
		run_control_reg & tick[0];
	assign cnt_en[1] = split_mode_select_reg ?
		run_control_reg & tick[1] :
		wrap[0];
	// in 16-bit mode the low byte reloads only on full 16-bit wrap, else it rolls to zero; split always reloads
	assign rld_en[0] = split_mode_select_reg |
		(cnt[1] == tcsf_pkg::BYTE_MAX);
	assign rld_en[1] = 1'b1;

	// overflow and capture events
	assign cap_evt = capture_mode_enable_reg & ext8_tick;
	assign hov_set = wrap[1] | cap_evt;
	assign lov_set = wrap[0];

	// hardware set beats a software clear in the same cycle
	assign high_overflow_flag_next = hov_set |
		(wr_ctrl ? pwdata[tcsf_pkg::HOV_BIT] : high_overflow_flag_reg);
	assign low_overflow_flag_next = lov_set |
		(wr_ctrl ? pwdata[tcsf_pkg::LOV_BIT] : low_overflow_flag_reg);

	// capture wins over a software reload write
	assign rld_next[0] = cap_evt ? cnt[0] :
		wr_rld[0] ? pwdata[7:0] : rld_reg[0];
	assign rld_next[1] = cap_evt ? cnt[1] :
		wr_rld[1] ? pwdata[7:0] : rld_reg[1];

	// only bits returned to software are cleared, so none is lost
	assign evt_st_next[tcsf_pkg::EVT_HOV] = hov_set |
		(evt_st_reg[tcsf_pkg::EVT_HOV] &
		~(rd_st & prdata_reg[tcsf_pkg::EVT_HOV]));
	assign evt_st_next[tcsf_pkg::EVT_LOV] = lov_set |
		(evt_st_reg[tcsf_pkg::EVT_LOV] &
		~(rd_st & prdata_reg[tcsf_pkg::EVT_LOV]));

	// interrupt: low events also need the low-byte enable
	assign timer_irq = ie_reg & (
		(evt_st_reg[tcsf_pkg::EVT_HOV] & evt_mask_reg[tcsf_pkg::EVT_HOV]) |
		(evt_st_reg[tcsf_pkg::EVT_LOV] & evt_mask_reg[tcsf_pkg::EVT_LOV] &
		low_overflow_irq_enable_reg));

	// flags, status and read data
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			high_overflow_flag_reg <= 1'b0;
			low_overflow_flag_reg <= 1'b0;
			evt_st_reg <= tcsf_pkg::FLD2_RST;
			rld_reg <= {tcsf_pkg::BYTE_RST, tcsf_pkg::BYTE_RST};
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			high_overflow_flag_reg <= high_overflow_flag_next;
			low_overflow_flag_reg <= low_overflow_flag_next;
			evt_st_reg <= evt_st_next;
			rld_reg <= rld_next;
			prdata_reg <= setup ? rd_mux : prdata_reg;
		end
	end

	// software-only control; bit 1 of the control word is not stored
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			low_overflow_irq_enable_reg <= 1'b0;
			capture_mode_enable_reg <= 1'b0;
			split_mode_select_reg <= 1'b0;
			run_control_reg <= 1'b0;
			external_clock_select_reg <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			low_overflow_irq_enable_reg <= pwdata[tcsf_pkg::LOIE_BIT];
			capture_mode_enable_reg <= pwdata[tcsf_pkg::CAPEN_BIT];
			split_mode_select_reg <= pwdata[tcsf_pkg::SPLIT_BIT];
			run_control_reg <= pwdata[tcsf_pkg::RUN_BIT];
			external_clock_select_reg <= pwdata[tcsf_pkg::XCLK_BIT];
		end
	end

	// clock select, interrupt enable and mask
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			clksel_reg <= tcsf_pkg::FLD2_RST;
			ie_reg <= 1'b0;
			evt_mask_reg <= tcsf_pkg::FLD2_RST;
		end
		else
		begin
			if (wr_acc & sel_clksel)
				clksel_reg <= pwdata[1:0];
			if (wr_acc & sel_ie)
				ie_reg <= pwdata[0];
			if (wr_acc & sel_mask)
				evt_mask_reg <= pwdata[1:0];
		end
	end

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_capture;
		capture_mode_enable_reg && ext8_tick;
	endsequence
	sequence s_wrap16;
		!split_mode_select_reg && cnt_en[0] &&
		cnt[0] == 8'hFF && cnt[1] == 8'hFF;
	endsequence
	sequence s_ctrl_read;
		setup && sel_ctrl && !pwrite;
	endsequence

	chk_high_byte_roll: assert property (
		split_mode_select_reg && cnt_en[1] && cnt[1] == 8'hFF &&
		!wr_cnt[1] |=> cnt[1] == $past(rld_reg[1]) && high_overflow_flag_reg)
		else $error("high rollover missed flag or reload");
	chk_wrap16_flag: assert property (
		s_wrap16 |=> high_overflow_flag_reg && evt_st_reg[0])
		else $error("16-bit wrap did not set high flag");
	chk_irq_follows: assert property (
		ie_reg && evt_mask_reg[0] && hov_set |=> timer_irq)
		else $error("no interrupt after high overflow");
	chk_flag_sticky: assert property (
		high_overflow_flag_reg && !(wr_ctrl && !pwdata[7])
		|=> high_overflow_flag_reg)
		else $error("high flag cleared without write");
	chk_low_flag_set: assert property (
		cnt_en[0] && cnt[0] == 8'hFF && !wr_cnt[0]
		|=> low_overflow_flag_reg &&
		cnt[0] == ($past(rld_en[0]) ? $past(rld_reg[0]) : 8'h00))
		else $error("low rollover missed flag");
	chk_low_irq_gate: assert property (
		!low_overflow_irq_enable_reg && !evt_st_reg[0] |-> !timer_irq)
		else $error("low interrupt without low enable");
	chk_run_hold: assert property (
		!split_mode_select_reg && !run_control_reg && !(|wr_cnt)
		|=> $stable(cnt))
		else $error("count moved while stopped");
	chk_low_free: assert property (
		split_mode_select_reg && tick[0] && cnt[0] != 8'hFF && !wr_cnt[0]
		|=> cnt[0] == $past(cnt[0]) + 8'h01)
		else $error("split low byte did not count");
	chk_unused_zero: assert property (
		s_ctrl_read |=> !prdata[1])
		else $error("unused control bit read one");
	chk_system_clock_sel: assert property (
		clksel_reg[0] && split_mode_select_reg |-> cnt_en[0])
		else $error("undivided clock not selected");
	chk_reload16: assert property (
		s_wrap16 ##0 (!(|wr_cnt)) |=> cnt[0] == $past(rld_reg[0]) &&
		cnt[1] == $past(rld_reg[1]))
		else $error("16-bit wrap did not reload");
	chk_carry16: assert property (
		!split_mode_select_reg && wrap[0] && cnt[1] != 8'hFF &&
		!(|wr_cnt) |=> cnt[1] == $past(cnt[1]) + 8'h01 && cnt[0] == 8'h00)
		else $error("high byte missed carry");
	chk_capture_copy: assert property (
		s_capture ##0 (!(|wr_cnt)) |=> rld_reg == $past(cnt) &&
		high_overflow_flag_reg)
		else $error("capture did not copy count");
endmodule
`default_nettype wire

// ---- design/tcsf_pkg.sv ----
// Purpose: shared constants of the timer control and status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register index times four gives the byte address
`default_nettype none
package tcsf_pkg;
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	// register indices; byte address is index times four
	localparam logic [7:0] IDX_CTRL = 8'h91;
	localparam logic [7:0] IDX_RLD_LO = 8'h92;
	localparam logic [7:0] IDX_RLD_HI = 8'h93;
	localparam logic [7:0] IDX_CNT_LO = 8'h94;
	localparam logic [7:0] IDX_CNT_HI = 8'h95;
	localparam logic [7:0] IDX_CLKSEL = 8'h96;
	localparam logic [7:0] IDX_IE = 8'h97;
	localparam logic [7:0] IDX_EVT_ST = 8'h98;
	localparam logic [7:0] IDX_EVT_MASK = 8'h99;
	// byte addresses
	localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] ADDR_RLD_LO = {2'h0, IDX_RLD_LO, 2'h0};
	localparam logic [11:0] ADDR_RLD_HI = {2'h0, IDX_RLD_HI, 2'h0};
	localparam logic [11:0] ADDR_CNT_LO = {2'h0, IDX_CNT_LO, 2'h0};
	localparam logic [11:0] ADDR_CNT_HI = {2'h0, IDX_CNT_HI, 2'h0};
	localparam logic [11:0] ADDR_CLKSEL = {2'h0, IDX_CLKSEL, 2'h0};
	localparam logic [11:0] ADDR_IE = {2'h0, IDX_IE, 2'h0};
	localparam logic [11:0] ADDR_EVT_ST = {2'h0, IDX_EVT_ST, 2'h0};
	localparam logic [11:0] ADDR_EVT_MASK = {2'h0, IDX_EVT_MASK, 2'h0};
	// timer_control field positions
	localparam int HOV_BIT = 7;
	localparam int LOV_BIT = 6;
	localparam int LOIE_BIT = 5;
	localparam int CAPEN_BIT = 4;
	localparam int SPLIT_BIT = 3;
	localparam int RUN_BIT = 2;
	localparam int UNUSED_BIT = 1;
	localparam int XCLK_BIT = 0;
	// clock_select_register fields: low and high byte system clock select
	localparam int LO_SYS_BIT = 0;
	localparam int HI_SYS_BIT = 1;
	// event status and mask fields
	localparam int EVT_HOV = 0;
	localparam int EVT_LOV = 1;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] FLD2_RST = 2'h0;
	// counting constants
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam logic [3:0] SYS_DIV = 4'hC;
	localparam logic [2:0] EXT_DIV_LAST = 3'h7;
endpackage
`default_nettype wire

// ---- design/tcsf_prescale.sv ----
// Purpose: timer clock enables from system and external sources
// Assumes: ext_osc is synchronous to clk_sys
// Notes: ticks are one-cycle pulses
`default_nettype none
module tcsf_prescale (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// external oscillator level
	input wire logic ext_osc,
	// clock enables
	output logic sys12_tick,
	output logic ext8_tick
);
	logic [3:0] div12_reg;
	logic [3:0] div12_next;
	logic [2:0] div8_reg;
	logic [2:0] div8_next;
	logic osc_prev_reg;
	logic osc_rise;

	// system clock divided by 12
	assign sys12_tick = div12_reg == tcsf_pkg::SYS_DIV - 4'h1;
	assign div12_next = sys12_tick ? 4'h0 : div12_reg + 4'h1;
	// div8 falls on the eighth rising edge; that edge is the tick
	assign osc_rise = ext_osc & ~osc_prev_reg;
	assign ext8_tick = osc_rise & (div8_reg == tcsf_pkg::EXT_DIV_LAST);
	assign div8_next = osc_rise ? div8_reg + 3'h1 : div8_reg;

	// divider state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			div12_reg <= 4'h0;
			div8_reg <= 3'h0;
			osc_prev_reg <= 1'b0;
		end
		else
		begin
			div12_reg <= div12_next;
			div8_reg <= div8_next;
			osc_prev_reg <= ext_osc;
		end
	end

	chk_div12_gap: assert property (@(posedge clk_sys) disable iff (rst)
		sys12_tick |=> !sys12_tick [*8] ##1 !sys12_tick [*3] ##1 sys12_tick)
		else $error("system divider not twelve");
endmodule
`default_nettype wire

// ---- design/tcsf_byte_cnt.sv ----
// Purpose: one 8-bit auto-reload counter byte
// Assumes: software write takes priority over counting
// Notes: wrap is a combinational one-cycle pulse
`default_nettype none
module tcsf_byte_cnt (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// counting control
	input wire logic count_en,
	input wire logic reload_en,
	input wire logic [7:0] reload_val,
	// software write
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// state
	output logic [7:0] count,
	output logic wrap
);
	logic [7:0] count_reg;
	logic [7:0] count_next;

	// roll over to reload value or to zero
	assign wrap = count_en & (count_reg == tcsf_pkg::BYTE_MAX);
	assign count_next = wr_en ? wr_data :
		wrap ? (reload_en ? reload_val : tcsf_pkg::BYTE_RST) :
		count_en ? count_reg + 8'h01 : count_reg;
	assign count = count_reg;

	// count register
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			count_reg <= tcsf_pkg::BYTE_RST;
		else
			count_reg <= count_next;
	end
endmodule
`default_nettype wire

// ---- test/tcsf_top_tb_top.sv ----
// Purpose: self-checking bench of the timer control and status block
// Assumes: zero-wait apb slave, ext_osc driven on clock edges
// Notes: counts are read after stopping the timer to avoid read races
`default_nettype none
module tcsf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_CT = tcsf_pkg::ADDR_CTRL;
	localparam logic [11:0] A_CL = tcsf_pkg::ADDR_CNT_LO;
	localparam logic [11:0] A_CH = tcsf_pkg::ADDR_CNT_HI;
	localparam logic [11:0] A_ST = tcsf_pkg::ADDR_EVT_ST;
	localparam logic [11:0] A_CK = tcsf_pkg::ADDR_CLKSEL;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_osc = 1'b0;
	logic timer_irq;
	logic [31:0] rd;
	logic err;
	int fails = 0;
	int checks = 0;
	int cycles = 0;

	// 40 MHz system clock
	always #12.5 clk_sys = ~clk_sys;

	tcsf_top tcsf_top_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ext_osc(ext_osc),
		.timer_irq(timer_irq)
	);

	task automatic print_verdict();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// in-range test, used where apb overhead blurs the exact count
	task automatic rng(input logic [11:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		apb(1'b0, a, 32'h0000_0000);
		chk({31'h0, (rd[7:0] >= lo && rd[7:0] <= hi)}, 32'h1);
	endtask

	// each pulse high two cycles, low two; the divider counts rises
	task automatic ext_pulses(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			ext_osc <= 1'b1;
			cyc(2);
			ext_osc <= 1'b0;
			cyc(1);
		end
	endtask

	// cut a hang short; the sequence needs under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails = fails + 1;
			print_verdict();
		end
	end

	initial
	begin
		cyc(6);
		rst <= 1'b0;
		// every register clears on reset
		for (int i = 0; i < 9; i++)
			rdc(A_CT + 12'(4 * i), 32'h0000_0000);
		chk({31'h0, timer_irq}, 32'h0);
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0000_0000);
		wr(A_CT, 32'h0000_0012);
		rdc(A_CT, 32'h0000_0010);
		// 16-bit on undivided clock: low wrap steps high byte
		wr(A_CT, 32'h0000_0000);
		wr(A_CK, 32'h0000_0001);
		wr(tcsf_pkg::ADDR_RLD_HI, 32'h0000_0012);
		wr(A_CL, 32'h0000_00F0);
		wr(A_CT, 32'h0000_0004);
		cyc(40);
		rdc(A_CT, 32'h0000_0044);
		wr(A_CT, 32'h0000_0040);
		rdc(A_CH, 32'h0000_0001);
		rdc(A_ST, 32'h0000_0002);
		rdc(A_ST, 32'h0000_0000);
		// full 16-bit wrap reloads and sets the high flag
		wr(A_CH, 32'h0000_00FF);
		wr(A_CL, 32'h0000_00F0);
		wr(A_CT, 32'h0000_0004);
		cyc(40);
		rdc(A_CT, 32'h0000_00C4);
		wr(A_CT, 32'h0000_00C0);
		rdc(A_CH, 32'h0000_0012);
		rdc(A_ST, 32'h0000_0003);
		cyc(20);
		rdc(A_CT, 32'h0000_00C0);
		wr(A_CT, 32'h0000_0000);
		rdc(A_CT, 32'h0000_0000);
		// interrupt from the high overflow
		wr(tcsf_pkg::ADDR_IE, 32'h0000_0001);
		wr(tcsf_pkg::ADDR_EVT_MASK, 32'h0000_0003);
		wr(A_CH, 32'h0000_00FF);
		wr(A_CL, 32'h0000_00F0);
		wr(A_CT, 32'h0000_0004);
		cyc(40);
		wr(A_CT, 32'h0000_0000);
		chk({31'h0, timer_irq}, 32'h1);
		rdc(A_ST, 32'h0000_0003);
		cyc(1);
		chk({31'h0, timer_irq}, 32'h0);
		// low overflow interrupts only with its own enable
		wr(A_CH, 32'h0000_0000);
		wr(A_CL, 32'h0000_00F0);
		wr(A_CT, 32'h0000_0004);
		cyc(40);
		wr(A_CT, 32'h0000_0000);
		chk({31'h0, timer_irq}, 32'h0);
		wr(A_CT, 32'h0000_0020);
		cyc(1);
		chk({31'h0, timer_irq}, 32'h1);
		wr(tcsf_pkg::ADDR_EVT_MASK, 32'h0000_0001);
		cyc(1);
		chk({31'h0, timer_irq}, 32'h0);
		wr(tcsf_pkg::ADDR_EVT_MASK, 32'h0000_0003);
		rdc(A_ST, 32'h0000_0002);
		// split: low runs with run control off, high holds
		wr(A_CT, 32'h0000_0000);
		wr(A_CL, 32'h0000_00F0);
		wr(tcsf_pkg::ADDR_RLD_LO, 32'h0000_0080);
		wr(A_CH, 32'h0000_0005);
		wr(A_CT, 32'h0000_0008);
		cyc(40);
		rdc(A_CT, 32'h0000_0048);
		wr(A_CT, 32'h0000_0040);
		rdc(A_CH, 32'h0000_0005);
		rng(A_CL, 8'h80, 8'hC0);
		// system clock divided by 12, about 125 cycles of counting
		wr(A_CT, 32'h0000_0000);
		wr(A_CK, 32'h0000_0000);
		wr(A_CL, 32'h0000_0000);
		wr(A_CT, 32'h0000_0004);
		cyc(120);
		wr(A_CT, 32'h0000_0000);
		rng(A_CL, 8'h09, 8'h0B);
		// external clock / 8 on both split bytes
		wr(A_CL, 32'h0000_0000);
		wr(A_CH, 32'h0000_0000);
		wr(A_CT, 32'h0000_000D);
		ext_pulses(64);
		cyc(8);
		wr(A_CT, 32'h0000_0001);
		rdc(A_CL, 32'h0000_0008);
		rdc(A_CH, 32'h0000_0008);
		// capture copies the count into the reload bytes
		wr(A_CK, 32'h0000_0001);
		wr(A_CL, 32'h0000_0000);
		wr(A_CT, 32'h0000_0014);
		ext_pulses(8);
		cyc(8);
		rdc(A_CT, 32'h0000_0094);
		wr(A_CT, 32'h0000_0080);
		rdc(tcsf_pkg::ADDR_RLD_HI, 32'h0000_0008);
		rng(tcsf_pkg::ADDR_RLD_LO, 8'h08, 8'h60);
		print_verdict();
	end
endmodule
`default_nettype wire
